//--- design/fsp_cfg.svh
// Purpose: constants of the flash self-program controller
// Assumes: one 200 MHz core clock; core accesses registers by select code
// Notes:   timing counts derive from the figures printed in their own units
//
// Behaviour
// [RULE_01] flash is rows of 14-bit words; row is the erase unit, 16 words
// [RULE_02] write latches of 14 bits filled through the data pair, 16 of them
// [RULE_03] unprogrammed words may be written without erasing the row first
// [RULE_04] software reads by loading address, clearing config select, set rd
// [RULE_05] the second instruction slot after the read strobe is not executed
// [RULE_06] read data lands in the data pair next cycle and holds till changed
// [RULE_07] software places two no-operations after setting the read strobe
// [RULE_08] erase, latch load and program start only after a full unlock
// [RULE_09] unlock is key 55h, key AAh, write strobe, two no-operations
// [RULE_10] setting the write strobe always forces two no-operation slots
// [RULE_11] row erase or program stalls execution until done, about 2 ms
// [RULE_12] a latch load forces the two slots and continues without stall
// [RULE_13] software should mask interrupts around the unlock sequence
// [RULE_14] erase works on whole rows; any address inside selects the row
// [RULE_15] erase: clear config select, set erase and permit, then unlock
// [RULE_16] during the stall only execution halts; clocks keep running
// [RULE_17] after erase execution resumes at third instruction after strobe
// [RULE_18] strobes are set by software only and cleared by hardware at end
// [RULE_19] write or erase needs write permit set; permit clears at power-up
// [RULE_20] write abort flag is set when reset interrupts a running write
// [RULE_21] the unlock key register is write only and reads as zero
// [RULE_22] key writes and strobe are consecutive accesses or unlock is lost
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// register select codes on the core access port
`define FSP_SEL_CTRL   3'h0
`define FSP_SEL_KEY    3'h1
`define FSP_SEL_DATL   3'h2
`define FSP_SEL_DATH   3'h3
`define FSP_SEL_ADRL   3'h4
`define FSP_SEL_ADRH   3'h5

// control register bit positions
`define FSP_BIT_RD     0
`define FSP_BIT_WR     1
`define FSP_BIT_WRITE_PERMIT   2
`define FSP_BIT_WRITE_ABORT_FLAG  3
`define FSP_BIT_FREE   4
`define FSP_BIT_LWLO   5
`define FSP_BIT_CONFIG_SPACE_SELECT   6

// unlock keys
`define FSP_KEY_FIRST  8'h55
`define FSP_KEY_SECOND 8'hAA

// geometry and reset values
`define FSP_ROW_WORDS  16
`define FSP_WORD_W     14
`define FSP_ADDR_W     15
`define FSP_BLANK      14'h3FFF

// erase or program time, and clock rate
`define FSP_OP_TIME_US 2000
`define FSP_CLK_MHZ    200
`define FSP_OP_CYCLES  (`FSP_OP_TIME_US * `FSP_CLK_MHZ)

`endif

//--- design/fsp_pkg.sv
// Purpose: shared types of the flash self-program controller
// Assumes: constants come from fsp_cfg.svh
// Notes:   holds types only
`include "fsp_cfg.svh"
package fsp_pkg;

  typedef enum logic [2:0] {
    FSP_IDLE, FSP_RD_S1, FSP_RD_S2, FSP_WR_S1, FSP_WR_S2, FSP_BUSY
  } fsp_state_t;

  // request to the flash array
  typedef struct packed {
    logic                   rd;
    logic                   erase;
    logic                   prog;
    logic                   cfg;
    logic [`FSP_ADDR_W-1:0] addr;
  } fsp_arr_req_t;

endpackage

//--- design/fsp_latches.sv
// Purpose: write latch row of the flash self-program controller
// Assumes: load and blank never asserted in the same cycle as a read-out
// Notes:   latches are not visible to software, only to the array
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module fsp_latches #(
  parameter int ROW_WORDS = `FSP_ROW_WORDS,
  parameter int IW        = $clog2(ROW_WORDS)
) (
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  input  wire logic                            load,
  input  wire logic [IW-1:0]                   idx,
  input  wire logic [`FSP_WORD_W-1:0]          wdata,
  input  wire logic                            blank,
  output logic      [ROW_WORDS*`FSP_WORD_W-1:0] row_data
);
  import fsp_pkg::*;

  // the index compare assumes the index exactly spans the row
  if (ROW_WORDS < 2 || IW != $clog2(ROW_WORDS)) begin : g_chk
    $error("fsp_latches: unsupported ROW_WORDS or IW");
  end

  logic [`FSP_WORD_W-1:0] lat_q [ROW_WORDS];

  // latches return to blank after every erase or program
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < ROW_WORDS; i++) begin
      if (rst || blank) begin
        lat_q[i] <= `FSP_BLANK;
      end else if (load && idx == IW'(i)) begin
        lat_q[i] <= wdata; // RULE_02
      end
    end
  end

  // flatten for the array, word 0 in the low bits
  always_comb begin
    for (int i = 0; i < ROW_WORDS; i++) begin
      row_data[i*`FSP_WORD_W +: `FSP_WORD_W] = lat_q[i];
    end
  end
endmodule
`default_nettype wire

//--- design/fsp_ctrl.sv
// Purpose: flash self-program controller, strobes, unlock, stall
// Assumes: instr_tick pulses once per instruction cycle, same clock domain
// Notes:   program only clears bits; erase-before-write is up to software
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module fsp_ctrl #(
  parameter int ROW_WORDS  = `FSP_ROW_WORDS,
  parameter int OP_CYCLES  = `FSP_OP_CYCLES
) (
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  input  wire logic                            instr_tick,
  input  wire logic                            reg_we,
  input  wire logic                            reg_re,
  input  wire logic [2:0]                      reg_sel,
  input  wire logic [7:0]                      reg_wdata,
  output logic      [7:0]                      reg_rdata,
  output logic                                 force_nop,
  output logic                                 stall,
  output fsp_pkg::fsp_arr_req_t                arr_req,
  output logic      [ROW_WORDS*`FSP_WORD_W-1:0] arr_row_data,
  input  wire logic [`FSP_WORD_W-1:0]          arr_rdata
);
  import fsp_pkg::*;

  localparam int IW = $clog2(ROW_WORDS);
  localparam int CW = $clog2(OP_CYCLES + 1);

  // the latch index is a low address slice, so the row must be a power of 2
  if (ROW_WORDS < 2 || (1 << IW) != ROW_WORDS || OP_CYCLES < 1) begin : g_chk
    $error("fsp_ctrl: unsupported ROW_WORDS or OP_CYCLES");
  end

  fsp_state_t             state_q;
  logic [1:0]             key_q;
  logic                   rd_q, wr_q, write_permit_q, write_abort_flag_q, free_q, lwlo_q, config_space_select_q;
  logic [`FSP_ADDR_W-1:0] addr_q;
  logic [`FSP_WORD_W-1:0] data_q;
  logic [CW-1:0]          cnt_q;
  logic                   arr_rd_q, arr_er_q, arr_pg_q;

  // decode of core accesses
  wire ctl_we   = reg_we && reg_sel == `FSP_SEL_CTRL;
  wire key_we   = reg_we && reg_sel == `FSP_SEL_KEY;
  wire any_acc  = reg_we || reg_re;
  wire unlocked = key_q == 2'd2;
  wire idle     = state_q == FSP_IDLE;
  wire wr_bit   = reg_wdata[`FSP_BIT_WR];
  wire write_permit_new = reg_wdata[`FSP_BIT_WRITE_PERMIT];
  // strobes only ever go from 0 to 1 by software
  wire rd_start = ctl_we && idle && reg_wdata[`FSP_BIT_RD] && !wr_bit;
  wire wr_start = ctl_we && idle && wr_bit && unlocked && write_permit_new;
  wire load_now = wr_start && reg_wdata[`FSP_BIT_LWLO]
                  && !reg_wdata[`FSP_BIT_FREE];
  wire prog_now = wr_start && !reg_wdata[`FSP_BIT_LWLO]
                  && !reg_wdata[`FSP_BIT_FREE];
  wire slot_end = (state_q == FSP_WR_S2) && instr_tick;
  wire op_done  = (state_q == FSP_BUSY) && cnt_q == '0;
  wire [IW-1:0] latch_idx = addr_q[IW-1:0];

  // handshake outputs to the core pipeline
  assign force_nop = state_q == FSP_WR_S1 || state_q == FSP_WR_S2 // RULE_10
                  || state_q == FSP_RD_S2;                        // RULE_05
  assign stall     = state_q == FSP_BUSY;                         // RULE_11 RULE_16

  // row address: low index bits dropped so any word picks its row
  assign arr_req.rd    = arr_rd_q;
  assign arr_req.erase = arr_er_q;
  assign arr_req.prog  = arr_pg_q;
  assign arr_req.cfg   = config_space_select_q;
  assign arr_req.addr  = (arr_er_q || arr_pg_q)
                       ? {addr_q[`FSP_ADDR_W-1:IW], IW'(0)}  // RULE_14 RULE_01
                       : addr_q;

  // read-back mux; the key register never shows what was written
  always_comb begin
    reg_rdata = 8'h00;
    case (reg_sel)
      `FSP_SEL_CTRL: reg_rdata = {1'b0, config_space_select_q, lwlo_q, free_q, write_abort_flag_q,
                                  write_permit_q, wr_q, rd_q};
      `FSP_SEL_KEY:  reg_rdata = 8'h00;                       // RULE_21
      `FSP_SEL_DATL: reg_rdata = data_q[7:0];
      `FSP_SEL_DATH: reg_rdata = {2'b00, data_q[13:8]};
      `FSP_SEL_ADRL: reg_rdata = addr_q[7:0];
      `FSP_SEL_ADRH: reg_rdata = {1'b0, addr_q[14:8]};
      default:       reg_rdata = 8'h00;
    endcase
  end

  // unlock tracker: any access other than the next expected step drops it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      key_q <= 2'd0;
    end else if (any_acc) begin
      if (key_we && reg_wdata == `FSP_KEY_FIRST) begin
        key_q <= 2'd1;                                        // RULE_09
      end else if (key_we && reg_wdata == `FSP_KEY_SECOND
                   && key_q == 2'd1) begin
        key_q <= 2'd2;
      end else begin
        key_q <= 2'd0;                                        // RULE_22 RULE_08
      end
    end
  end

  // control bits; a reset during a row operation leaves the abort flag set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_abort_flag_q <= write_abort_flag_q || (state_q == FSP_BUSY);            // RULE_20
      write_permit_q  <= 1'b0;                                        // RULE_19
      free_q  <= 1'b0;
      lwlo_q  <= 1'b0;
      config_space_select_q  <= 1'b0;
    end else if (ctl_we) begin
      write_abort_flag_q <= reg_wdata[`FSP_BIT_WRITE_ABORT_FLAG];
      write_permit_q  <= write_permit_new;
      free_q  <= reg_wdata[`FSP_BIT_FREE];
      lwlo_q  <= reg_wdata[`FSP_BIT_LWLO];
      config_space_select_q  <= reg_wdata[`FSP_BIT_CONFIG_SPACE_SELECT];
    end
  end

  // address pair and data pair; a finished read overwrites the data pair
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_q <= '0;
      data_q <= '0;
    end else begin
      if (reg_we && reg_sel == `FSP_SEL_ADRL) addr_q[7:0]  <= reg_wdata;
      if (reg_we && reg_sel == `FSP_SEL_ADRH) addr_q[14:8] <= reg_wdata[6:0];
      if (arr_rd_q) begin
        data_q <= arr_rdata;                                  // RULE_06
      end else begin
        if (reg_we && reg_sel == `FSP_SEL_DATL) data_q[7:0]  <= reg_wdata;
        if (reg_we && reg_sel == `FSP_SEL_DATH) data_q[13:8] <= reg_wdata[5:0];
      end
    end
  end

  // sequencer: forced slots on instruction ticks, then the timed stall
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q  <= FSP_IDLE;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      cnt_q    <= '0;
      arr_rd_q <= 1'b0;
      arr_er_q <= 1'b0;
      arr_pg_q <= 1'b0;
    end else begin
      arr_rd_q <= 1'b0;
      arr_er_q <= 1'b0;
      arr_pg_q <= 1'b0;
      case (state_q)
        FSP_IDLE: begin
          if (wr_start) begin
            wr_q    <= 1'b1;                                  // RULE_08 RULE_19
            state_q <= FSP_WR_S1;
          end else if (rd_start) begin
            rd_q    <= 1'b1;
            state_q <= FSP_RD_S1;
          end
        end
        FSP_RD_S1: begin
          if (instr_tick) begin
            state_q  <= FSP_RD_S2;
            arr_rd_q <= 1'b1;                                 // RULE_05
          end
        end
        FSP_RD_S2: begin
          if (arr_rd_q) rd_q <= 1'b0;                         // RULE_18
          if (instr_tick) state_q <= FSP_IDLE;
        end
        FSP_WR_S1: begin
          if (instr_tick) state_q <= FSP_WR_S2;
        end
        FSP_WR_S2: begin
          if (instr_tick) begin
            if (lwlo_q && !free_q) begin
              wr_q    <= 1'b0;                                // RULE_12 RULE_18
              state_q <= FSP_IDLE;
            end else begin
              arr_er_q <= free_q;                             // RULE_14
              arr_pg_q <= !free_q;                            // RULE_03
              cnt_q    <= CW'(OP_CYCLES - 1);
              state_q  <= FSP_BUSY;                           // RULE_11
            end
          end
        end
        FSP_BUSY: begin
          if (op_done) begin
            wr_q    <= 1'b0;                                  // RULE_18
            state_q <= FSP_IDLE;                              // RULE_17
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        default: state_q <= FSP_IDLE;
      endcase
    end
  end

  // latch row; the word in the data pair is taken as the strobe is accepted
  fsp_latches #(
    .ROW_WORDS (ROW_WORDS),
    .IW        (IW)
  ) u_latches (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (load_now || prog_now),                         // RULE_02
    .idx      (latch_idx),
    .wdata    (data_q),
    .blank    (op_done),
    .row_data (arr_row_data)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_key_reads_zero: assert property ( // RULE_21
    reg_sel == `FSP_SEL_KEY |-> reg_rdata == 8'h00)
    else $error("key register read not zero");

  chk_wr_needs_unlock: assert property ( // RULE_08
    idle && ctl_we && wr_bit && !unlocked |=> !wr_q)
    else $error("write strobe accepted without unlock");

  chk_wr_needs_permit: assert property ( // RULE_19
    $rose(wr_q) |-> write_permit_q)
    else $error("write strobe set while permit clear");

  chk_read_data_lands: assert property ( // RULE_06
    arr_req.rd |=> data_q == $past(arr_rdata) && !rd_q)
    else $error("read data not in data pair next cycle");

  // every cycle between write strobe accept and stall or idle is a forced slot
  chk_strobe_slots_nop: assert property ( // RULE_10
    wr_q && !stall |-> force_nop)
    else $error("write strobe slot not forced");

  chk_load_no_stall: assert property ( // RULE_12
    slot_end && lwlo_q && !free_q |=> idle && !stall && !wr_q)
    else $error("latch load caused a stall");

  chk_busy_length: assert property ( // RULE_11
    $rose(stall) |-> stall && cnt_q == CW'(OP_CYCLES - 1))
    else $error("stall did not start with full count");

  chk_stall_end_clears: assert property ( // RULE_18
    $fell(stall) |-> !wr_q && idle)
    else $error("write strobe not cleared at end of operation");

  chk_erase_row_addr: assert property ( // RULE_14
    arr_req.erase |-> arr_req.addr[IW-1:0] == '0 && stall)
    else $error("erase address not row aligned");

  chk_read_second_slot: assert property ( // RULE_05
    state_q == FSP_RD_S1 && instr_tick |=> arr_req.rd && force_nop)
    else $error("read access not in second slot");
endmodule
`default_nettype wire

//--- sim/fsp_far_model.sv
// Purpose: flash array and instruction pacing facing the controller
// Assumes: a 256-word window of the array is enough for the bench
// Notes:   programming only clears bits, as real cells do
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module fsp_far_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  rst,
  input  wire fsp_pkg::fsp_arr_req_t                 arr_req,
  input  wire logic [`FSP_ROW_WORDS*`FSP_WORD_W-1:0] arr_row_data,
  output logic                                       instr_tick,
  output logic      [`FSP_WORD_W-1:0]                arr_rdata
);
  import fsp_pkg::*;
  logic [`FSP_WORD_W-1:0] mem [256];
  logic [`FSP_WORD_W-1:0] junk_q = 14'h2A5A;
  int                     tick_q = 0;
  wire  [7:0]             row_base = {arr_req.addr[7:4], 4'h0};

  // bus is only meaningful while reading; otherwise it toggles
  assign arr_rdata = arr_req.rd ? mem[arr_req.addr[7:0]] : junk_q;
  initial instr_tick = 1'b0;
  initial foreach (mem[i]) mem[i] = `FSP_BLANK;

  // clocks keep running through a stall, so ticks never pause
  always @(posedge core_clk) begin
    junk_q <= ~junk_q;
    tick_q <= (rst || tick_q == TICK_DIV - 1) ? 0 : tick_q + 1;
    instr_tick <= !rst && tick_q == TICK_DIV - 1;
    for (int i = 0; i < `FSP_ROW_WORDS; i++) begin
      if (arr_req.erase)
        mem[row_base | 8'(i)] <= `FSP_BLANK;
      if (arr_req.prog)
        mem[row_base | 8'(i)] <= mem[row_base | 8'(i)] &
          arr_row_data[i*`FSP_WORD_W +: `FSP_WORD_W];
    end
  end
endmodule
`default_nettype wire

//--- sim/test_flash_self_program_ctrl.sv
// Purpose: self-checking bench for the flash self-program controller
// Assumes: operation time shortened to OP_CYC clocks
// Notes:   port driven at rising edges, sampled at falling edges
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module test_flash_self_program_ctrl;
  import fsp_pkg::*;
  localparam int OP_CYC = 20;
  logic         core_clk  = 1'b0;
  logic         rst       = 1'b1;
  logic         reg_we    = 1'b0;
  logic         reg_re    = 1'b0;
  logic [2:0]   reg_sel   = 3'h0;
  logic [7:0]   reg_wdata = 8'h00;
  logic [7:0]   reg_rdata;
  logic         force_nop;
  logic         stall;
  logic         instr_tick;
  fsp_arr_req_t arr_req;
  logic [`FSP_ROW_WORDS*`FSP_WORD_W-1:0] row_data;
  logic [`FSP_WORD_W-1:0] arr_rdata;
  int           err_total   = 0;
  int           checks_done = 0;
  int           cycles      = 0;
  int           n_stall;
  logic         nop_seen;
  logic [7:0]   rv;
  logic [7:0]   lo;

  fsp_ctrl #(.OP_CYCLES(OP_CYC)) i_dut (.core_clk(core_clk), .rst(rst),
    .instr_tick(instr_tick), .reg_we(reg_we), .reg_re(reg_re),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .force_nop(force_nop), .stall(stall), .arr_req(arr_req),
    .arr_row_data(row_data), .arr_rdata(arr_rdata));
  fsp_far_model i_far (.core_clk(core_clk), .rst(rst),
    .arr_req(arr_req), .arr_row_data(row_data),
    .instr_tick(instr_tick), .arr_rdata(arr_rdata));

  // clock and a hang guard well above the expected run length
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // one access per call; a quiet cycle always follows the strobe
  task automatic wr_reg(logic [2:0] sel, logic [7:0] d);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_sel <= sel;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd_reg(logic [2:0] sel);
    @(posedge core_clk);
    reg_re <= 1'b1;
    reg_sel <= sel;
    @(negedge core_clk);
    rv = reg_rdata;
    @(posedge core_clk);
    reg_re <= 1'b0;
  endtask

  // peeks at the control bits without a read strobe, so nothing breaks
  task automatic wait_idle();
    n_stall = 0;
    nop_seen = 1'b0;
    reg_sel <= `FSP_SEL_CTRL;
    for (int i = 0; i < 400; i++) begin
      @(negedge core_clk);
      if (stall === 1'b1) n_stall++;
      if (force_nop === 1'b1) nop_seen = 1'b1;
      if (reg_rdata[1:0] === 2'b00 && stall === 1'b0 &&
          force_nop === 1'b0) return;
    end
    check("idle wait", 16'h0000, 16'h0001);
  endtask

  // no interrupt source exists here, so keys and strobe run unbroken
  task automatic unlock(logic [7:0] c);
    wr_reg(`FSP_SEL_KEY, `FSP_KEY_FIRST);
    wr_reg(`FSP_SEL_KEY, `FSP_KEY_SECOND);
    wr_reg(`FSP_SEL_CTRL, c);
  endtask

  task automatic read_word(logic [14:0] a, logic [13:0] exp);
    wr_reg(`FSP_SEL_ADRL, a[7:0]);
    wr_reg(`FSP_SEL_ADRH, {1'b0, a[14:8]});
    wr_reg(`FSP_SEL_CTRL, 8'h01); // select clear, then strobe
    wait_idle();
    check("read squash", 16'(nop_seen), 16'h0001);
    rd_reg(`FSP_SEL_CTRL);
    check("rd clear", 16'(rv[0]), 16'h0000);
    rd_reg(`FSP_SEL_DATL);
    lo = rv;
    rd_reg(`FSP_SEL_DATH);
    check("read data", {2'b00, rv[5:0], lo}, 16'(exp));
  endtask

  // latch word through the data pair, then start with control value c
  task automatic load(logic [7:0] a, logic [13:0] d, logic [7:0] c);
    wr_reg(`FSP_SEL_ADRH, 8'h00);
    wr_reg(`FSP_SEL_ADRL, a);
    wr_reg(`FSP_SEL_DATL, d[7:0]);
    wr_reg(`FSP_SEL_DATH, {2'b00, d[13:8]});
    unlock(c);
    wait_idle();
  endtask

  task automatic t_reset();
    rd_reg(`FSP_SEL_CTRL);
    check("ctrl reset", 16'(rv & 8'hF7), 16'h0000);
    wr_reg(`FSP_SEL_KEY, `FSP_KEY_FIRST);
    rd_reg(`FSP_SEL_KEY);
    check("key read", 16'(rv), 16'h0000);
    wr_reg(3'h7, 8'hFF);
    rd_reg(3'h7);
    check("unmapped", 16'(rv), 16'h0000);
    wr_reg(`FSP_SEL_CTRL, 8'h40);
    rd_reg(`FSP_SEL_CTRL);
    check("cfg bit", 16'(rv), 16'h0040);
    check("cfg to array", 16'(arr_req.cfg), 16'h0001);
  endtask

  task automatic t_read();
    i_far.mem[8'h9C] = 14'h2D4B;
    read_word(15'h009C, 14'h2D4B);
    check("cfg cleared", 16'(arr_req.cfg), 16'h0000);
    repeat (9) @(negedge core_clk);
    rd_reg(`FSP_SEL_DATL);
    check("data hold", 16'(rv), 16'h004B);
    wr_reg(`FSP_SEL_DATL, 8'h11);
    rd_reg(`FSP_SEL_DATL);
    check("data write", 16'(rv), 16'h0011);
  endtask

  // no keys, keys broken by a read, keys without permit
  task automatic t_refused();
    for (int k = 0; k < 3; k++) begin
      if (k != 0) wr_reg(`FSP_SEL_KEY, `FSP_KEY_FIRST);
      if (k == 1) rd_reg(`FSP_SEL_CTRL);
      if (k != 0) wr_reg(`FSP_SEL_KEY, `FSP_KEY_SECOND);
      wr_reg(`FSP_SEL_CTRL, (k == 2) ? 8'h12 : 8'h16);
      wait_idle();
      check("refused stall", 16'(n_stall), 16'h0000);
      check("refused nop", 16'(nop_seen), 16'h0000);
    end
  endtask

  task automatic t_erase();
    i_far.mem[8'h35] = 14'h0123;
    i_far.mem[8'h3A] = 14'h0456;
    i_far.mem[8'h2F] = 14'h0777;
    wr_reg(`FSP_SEL_ADRH, 8'h00);
    wr_reg(`FSP_SEL_ADRL, 8'h37);
    unlock(8'h16); // permit and erase select
    @(negedge core_clk);
    check("erase nop", 16'(force_nop), 16'h0001);
    wait_idle();
    check("erase stall", 16'(n_stall), 16'(OP_CYC));
    read_word(15'h0035, `FSP_BLANK);
    read_word(15'h003A, `FSP_BLANK);
    read_word(15'h002F, 14'h0777);
  endtask

  task automatic t_load_prog();
    load(8'h42, 14'h1A5C, 8'h26);
    check("load stall", 16'(n_stall), 16'h0000);
    check("load nop", 16'(nop_seen), 16'h0001);
    load(8'h45, 14'h2B3F, 8'h06);
    check("prog stall", 16'(n_stall), 16'(OP_CYC));
    read_word(15'h0042, 14'h1A5C);
    read_word(15'h0045, 14'h2B3F);
    read_word(15'h0047, `FSP_BLANK);
    load(8'h48, 14'h0F0F, 8'h06);
    read_word(15'h0048, 14'h0F0F);
    read_word(15'h0042, 14'h1A5C);
  endtask

  // erase and latch-load both selected: erase must win and stall
  task automatic t_abort();
    unlock(8'h36);
    repeat (10) @(negedge core_clk);
    check("abort stall", 16'(stall), 16'h0001);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd_reg(`FSP_SEL_CTRL);
    check("abort flag", 16'(rv[3:2]), 16'h0002);
  endtask

  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_read();
    t_refused();
    t_erase();
    t_load_prog();
    t_abort();
    end_of_test();
  end
endmodule
`default_nettype wire
